// [csi_status_irq.sv]
// Status flags, interrupt flags and host register port of a CAN controller.
// Assumes a protocol engine on the same clock that reports message, transmit
// and error events as one-cycle pulses and bus activity as levels.
//
// The implementer's own choice: the strobed register port.
module csi_status_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host register port
  input wire logic [csi_pkg::ADDR_W-1:0] addr,
  input wire logic [csi_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [csi_pkg::DATA_W-1:0] rdata,
  // Protocol engine events and levels
  input wire logic msg_start,
  input wire logic msg_done,
  input wire logic msg_abort,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic tx_ok,
  input wire logic warn_level,
  input wire logic bus_off_evt,
  input wire logic bus_free,
  // Controls to the protocol engine
  output logic store_en,
  output logic tx_request,
  output logic err_cnt_clear,
  output logic init_hold,
  output logic sleep,
  // Transmit buffer write port
  output logic tx_buf_we,
  output logic [csi_pkg::TXB_IDX_W-1:0] tx_buf_idx,
  output logic [csi_pkg::DATA_W-1:0] tx_buf_data,
  // Interrupt
  output logic irq_n
);
  csi_rec_if rec ();

  logic init_hold_ff;
  logic [3:0] irq_en_ff;
  logic rx_buffer_full_ff;
  logic [1:0] rbuf_cnt_ff;
  logic overrun_ff;
  logic drop_ff;
  logic tx_complete_ff;
  logic error_warning_ff;
  logic bus_off_ff;
  logic sleep_ff;
  logic [csi_pkg::IRQ_W-1:0] irq_flags_ff;
  logic [csi_pkg::DATA_W-1:0] rdata_ff;
  logic tx_buf_we_ff;
  logic [csi_pkg::TXB_IDX_W-1:0] tx_buf_idx_ff;
  logic [csi_pkg::DATA_W-1:0] tx_buf_data_ff;
  csi_pkg::csi_tx_state_t tx_state_ff;
  csi_pkg::csi_tx_state_t nxt_tx_state;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire ctrl_wr = wr && (addr == csi_pkg::CTRL_ADDR);
  wire cmd_wr = wr && (addr == csi_pkg::CMD_ADDR);
  wire ir_rd = rd && (addr == csi_pkg::IRQ_ADDR);
  wire txb_hit = (addr >= csi_pkg::TXB_FIRST) && (addr <= csi_pkg::TXB_LAST);
  wire [csi_pkg::ADDR_W-1:0] txb_off = addr - csi_pkg::TXB_FIRST;
  // Transmit commands are ignored while init hold keeps the controller idle
  wire cmd_send = cmd_wr && wdata[csi_pkg::CMD_SEND_REQ] && !init_hold_ff;
  wire cmd_cancel = cmd_wr && wdata[csi_pkg::CMD_CANCEL_SEND] && !init_hold_ff;
  wire cmd_free = cmd_wr && wdata[csi_pkg::CMD_FREE_RX_BUFFER];
  wire cmd_clr_ovr = cmd_wr && wdata[csi_pkg::CMD_CLEAR_OVERRUN];
  wire tx_buffer_free = (tx_state_ff == csi_pkg::CSI_TX_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffers and overrun
  // Engine raises msg_start for own transmitted accepted frames as well
  wire overrun_evt = msg_start && (rbuf_cnt_ff == csi_pkg::RBUF_NUM) && !init_hold_ff;
  wire store_ok = msg_done && !drop_ff && !init_hold_ff;
  // The count falls when the host frees buffers after reading, and init hold clears it
  wire free_ok = cmd_free && (rbuf_cnt_ff != csi_pkg::RBUF_EMPTY);
  // A second buffered message becomes visible as soon as the first is freed
  wire rbf_set = store_ok || (free_ok && (rbuf_cnt_ff == csi_pkg::RBUF_NUM));
  wire nxt_rbf = rbf_set || (rx_buffer_full_ff && !cmd_free);
  wire [1:0] nxt_rbuf_cnt = (store_ok && !free_ok) ? rbuf_cnt_ff + csi_pkg::RBUF_ONE :
                            (!store_ok && free_ok) ? rbuf_cnt_ff - csi_pkg::RBUF_ONE :
                            rbuf_cnt_ff;
  // Set wins over a clear-overrun command in the same cycle
  wire nxt_overrun = overrun_evt || (overrun_ff && !cmd_clr_ovr);
  wire nxt_drop = overrun_evt || (drop_ff && !msg_done && !msg_abort);
  assign store_en = !drop_ff && !overrun_evt;

  always_ff @(posedge clk) begin
    if (rst || init_hold_ff) begin
      rx_buffer_full_ff <= 1'b0;
      rbuf_cnt_ff <= csi_pkg::RBUF_EMPTY;
      overrun_ff <= 1'b0;
      drop_ff <= 1'b0;
    end else begin
      rx_buffer_full_ff <= nxt_rbf;
      rbuf_cnt_ff <= nxt_rbuf_cnt;
      overrun_ff <= nxt_overrun;
      drop_ff <= nxt_drop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequence
  // A failed attempt falls back to pending so the engine retries on its own
  always_comb begin
    nxt_tx_state = tx_state_ff;
    unique case (tx_state_ff)
      csi_pkg::CSI_TX_IDLE: begin
        if (cmd_send) begin
          nxt_tx_state = csi_pkg::CSI_TX_PEND;
        end
      end
      csi_pkg::CSI_TX_PEND: begin
        if (tx_ok || cmd_cancel) begin
          nxt_tx_state = csi_pkg::CSI_TX_IDLE;
        end else if (tx_active) begin
          nxt_tx_state = csi_pkg::CSI_TX_SEND;
        end
      end
      csi_pkg::CSI_TX_SEND: begin
        // A frame already on the bus is not stopped by a cancel
        if (tx_ok) begin
          nxt_tx_state = csi_pkg::CSI_TX_IDLE;
        end else if (!tx_active) begin
          nxt_tx_state = csi_pkg::CSI_TX_PEND;
        end
      end
      default: nxt_tx_state = csi_pkg::CSI_TX_IDLE;
    endcase
  end

  wire tx_done_ok = tx_ok && !tx_buffer_free;
  wire nxt_tx_complete = cmd_send ? 1'b0 : (tx_done_ok ? 1'b1 : tx_complete_ff);
  wire tx_free_rise = !tx_buffer_free && (nxt_tx_state == csi_pkg::CSI_TX_IDLE);
  assign tx_request = !tx_buffer_free;

  always_ff @(posedge clk) begin
    if (rst || init_hold_ff) begin
      tx_state_ff <= csi_pkg::CSI_TX_IDLE;
      tx_complete_ff <= 1'b1;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_complete_ff <= nxt_tx_complete;
    end
  end

  // Locked-buffer writes vanish with no trace anywhere
  wire txb_wr = wr && txb_hit && tx_buffer_free;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buf_we_ff <= 1'b0;
      tx_buf_idx_ff <= '0;
      tx_buf_data_ff <= csi_pkg::ZERO_BYTE;
    end else begin
      tx_buf_we_ff <= txb_wr;
      tx_buf_idx_ff <= txb_wr ? txb_off[csi_pkg::TXB_IDX_W-1:0] : tx_buf_idx_ff;
      tx_buf_data_ff <= txb_wr ? wdata : tx_buf_data_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error state, bus-off and recovery
  wire bus_rise = bus_off_evt && !bus_off_ff;
  wire nxt_bus_off = bus_off_evt || (bus_off_ff && !rec.done);
  wire nxt_warn = warn_level && !rec.done;
  wire err_chg = (nxt_warn != error_warning_ff) || (nxt_bus_off != bus_off_ff);
  // Bus-off wins over a host write in the same cycle
  wire nxt_init_hold = bus_rise ? 1'b1 :
                       (ctrl_wr ? wdata[csi_pkg::CR_INIT_HOLD] : init_hold_ff);
  assign rec.run = bus_off_ff && !init_hold_ff;
  assign rec.bus_free = bus_free;
  assign err_cnt_clear = rec.done;
  assign init_hold = init_hold_ff;

  csi_rec_cnt u_rec_cnt (
    .clk (clk),
    .rst (rst),
    .rec (rec.cnt)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      init_hold_ff <= 1'b1;
      irq_en_ff <= csi_pkg::CR_EN_RESET;
      error_warning_ff <= 1'b0;
      bus_off_ff <= 1'b0;
    end else begin
      init_hold_ff <= nxt_init_hold;
      irq_en_ff <= ctrl_wr ? wdata[csi_pkg::CR_OVERRUN_IRQ_EN:csi_pkg::CR_RX_IRQ_EN] : irq_en_ff;
      error_warning_ff <= nxt_warn;
      bus_off_ff <= nxt_bus_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep; receive activity or a pending interrupt wakes the controller
  wire sleep_ok = !rx_active && !tx_active && irq_n;
  wire nxt_sleep = cmd_wr ? (wdata[csi_pkg::CMD_SLEEP] && sleep_ok) :
                   (sleep_ff && !rx_active && irq_n);
  wire wake_evt = sleep_ff && !nxt_sleep;
  assign sleep = sleep_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= nxt_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags; a set in the read cycle survives the clear
  wire [csi_pkg::IRQ_W-1:0] irq_set;
  assign irq_set[csi_pkg::IR_RX] = rbf_set && irq_en_ff[csi_pkg::CR_RX_IRQ_EN-1];
  assign irq_set[csi_pkg::IR_TX] = tx_free_rise && irq_en_ff[csi_pkg::CR_TX_IRQ_EN-1];
  assign irq_set[csi_pkg::IR_ERR] = err_chg && irq_en_ff[csi_pkg::CR_ERR_IRQ_EN-1];
  assign irq_set[csi_pkg::IR_OVERRUN] =
    overrun_evt && irq_en_ff[csi_pkg::CR_OVERRUN_IRQ_EN-1];
  assign irq_set[csi_pkg::IR_WAKEUP] = wake_evt;
  wire [csi_pkg::IRQ_W-1:0] nxt_irq_flags =
    (irq_flags_ff & ~{csi_pkg::IRQ_W{ir_rd}}) | irq_set;
  assign irq_n = ~|irq_flags_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_flags_ff <= csi_pkg::IR_RESET;
    end else begin
      irq_flags_ff <= nxt_irq_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [csi_pkg::DATA_W-1:0] stat_byte = {bus_off_ff, error_warning_ff, tx_active, rx_active,
    tx_complete_ff, tx_buffer_free, overrun_ff, rx_buffer_full_ff};
  wire [csi_pkg::DATA_W-1:0] ctrl_byte = {3'h0, irq_en_ff, init_hold_ff};
  wire [csi_pkg::DATA_W-1:0] rd_mux =
    (addr == csi_pkg::CTRL_ADDR) ? ctrl_byte :
    (addr == csi_pkg::CMD_ADDR) ? csi_pkg::CMD_READ_VAL :
    (addr == csi_pkg::STAT_ADDR) ? stat_byte :
    (addr == csi_pkg::IRQ_ADDR) ? {3'h0, irq_flags_ff} :
    csi_pkg::ZERO_BYTE;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= csi_pkg::ZERO_BYTE;
    end else begin
      rdata_ff <= rd ? rd_mux : csi_pkg::ZERO_BYTE;
    end
  end

  assign rdata = rdata_ff;
  assign tx_buf_we = tx_buf_we_ff;
  assign tx_buf_idx = tx_buf_idx_ff;
  assign tx_buf_data = tx_buf_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_send_cmd;
    cmd_send && !init_hold_ff;
  endsequence

  sequence s_tx_locked;
    !tx_buffer_free && !tx_complete_ff;
  endsequence

  sequence s_rec_done;
    rec.done ##1 (!bus_off_ff && !error_warning_ff);
  endsequence

  a_rbf_store_set: assert property (store_ok |=> rx_buffer_full_ff)
    else $error("rx_buffer_full not set after store");
  a_rbf_free_clr: assert property (cmd_free && !store_ok && rbuf_cnt_ff != csi_pkg::RBUF_NUM
    |=> !rx_buffer_full_ff)
    else $error("rx_buffer_full not cleared by free command");
  a_ovr_flag_set: assert property (overrun_evt |=> overrun_ff && drop_ff)
    else $error("overrun not flagged");
  a_ovr_no_store: assert property (overrun_evt |-> !store_en ##1 (drop_ff && !store_en))
    else $error("overrun message not dropped");
  // Completion of a dropped message must leave the buffer count alone
  a_drop_no_count: assert property (drop_ff && msg_done && !cmd_free && !init_hold_ff
    |=> $stable(rbuf_cnt_ff))
    else $error("dropped message counted");
  a_tx_send_lock: assert property (s_send_cmd |=> s_tx_locked)
    else $error("send request did not lock buffer");
  a_tx_lock_write: assert property (wr && txb_hit && !tx_buffer_free |=> !tx_buf_we)
    else $error("locked write reached transmit buffer");
  a_tx_ok_done: assert property (tx_done_ok && !cmd_send
    |=> tx_complete_ff && tx_buffer_free)
    else $error("successful send not completed");
  a_tx_cmd_low: assert property (cmd_send |=> !tx_complete_ff)
    else $error("send request left tx_complete high");
  a_tx_cancel: assert property (tx_state_ff == csi_pkg::CSI_TX_PEND && cmd_cancel && !tx_ok
    |=> tx_buffer_free && !tx_complete_ff)
    else $error("cancel handled wrongly");
  a_busoff_hold: assert property ($rose(bus_off_ff) |-> init_hold_ff)
    else $error("bus-off without init hold");
  a_rec_clear: assert property (rec.done |-> err_cnt_clear ##0 s_rec_done)
    else $error("recovery did not clear error state");
  a_irq_pin: assert property (irq_n == (irq_flags_ff == csi_pkg::IR_RESET))
    else $error("interrupt pin disagrees with flags");
  a_ir_read_clr: assert property (ir_rd && irq_set == csi_pkg::IR_RESET
    |=> irq_flags_ff == csi_pkg::IR_RESET ##0 rdata == {3'h0, $past(irq_flags_ff)})
    else $error("flag read did not return and clear");
  a_rx_irq_set: assert property (rbf_set && irq_en_ff[0]
    |=> irq_flags_ff[csi_pkg::IR_RX])
    else $error("rx_irq missing");
  a_ovr_irq_set: assert property (overrun_evt
    && irq_en_ff[csi_pkg::CR_OVERRUN_IRQ_EN-1]
    |=> irq_flags_ff[csi_pkg::IR_OVERRUN] && overrun_ff)
    else $error("overrun interrupt missing");
  a_warn_follow: assert property (!rec.done |=> error_warning_ff == $past(warn_level))
    else $error("error_warning does not follow warning level");
  a_wake_irq: assert property ($fell(sleep_ff) |-> irq_flags_ff[csi_pkg::IR_WAKEUP])
    else $error("wakeup_irq missing");
endmodule

// [csi_pkg.sv]
// Constants for the CAN status and interrupt-flag block.
// Assumes an 8-bit host register port and a single 50 MHz clock.
package csi_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 5;
  localparam int TXB_IDX_W = 4;
  // Register map
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] CMD_ADDR = 5'h01;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 5'h02;
  localparam logic [ADDR_W-1:0] IRQ_ADDR = 5'h03;
  localparam logic [ADDR_W-1:0] TXB_FIRST = 5'h0A;
  localparam logic [ADDR_W-1:0] TXB_LAST = 5'h13;
  localparam logic [DATA_W-1:0] CMD_READ_VAL = 8'hFF;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // Control register bits
  localparam int CR_INIT_HOLD = 0;
  localparam int CR_RX_IRQ_EN = 1;
  localparam int CR_TX_IRQ_EN = 2;
  localparam int CR_ERR_IRQ_EN = 3;
  localparam int CR_OVERRUN_IRQ_EN = 4;
  localparam logic [3:0] CR_EN_RESET = 4'h0;
  // Command register bits
  localparam int CMD_SEND_REQ = 0;
  localparam int CMD_CANCEL_SEND = 1;
  localparam int CMD_FREE_RX_BUFFER = 2;
  localparam int CMD_CLEAR_OVERRUN = 3;
  localparam int CMD_SLEEP = 4;
  // Interrupt flag bits
  localparam int IR_RX = 0;
  localparam int IR_TX = 1;
  localparam int IR_ERR = 2;
  localparam int IR_OVERRUN = 3;
  localparam int IR_WAKEUP = 4;
  localparam logic [IRQ_W-1:0] IR_RESET = 5'h00;
  // Receive buffers
  localparam logic [1:0] RBUF_NUM = 2'h2;
  localparam logic [1:0] RBUF_ONE = 2'h1;
  localparam logic [1:0] RBUF_EMPTY = 2'h0;
  // Bus-off recovery
  localparam int REC_CNT_W = 8;
  localparam logic [REC_CNT_W-1:0] BUS_FREE_COUNT = 8'h80;
  localparam logic [REC_CNT_W-1:0] REC_CNT_ONE = 8'h01;
  localparam logic [REC_CNT_W-1:0] REC_CNT_ZERO = 8'h00;
  // Transmit sequence
  typedef enum logic [2:0] {
    CSI_TX_IDLE = 3'h1,
    CSI_TX_PEND = 3'h2,
    CSI_TX_SEND = 3'h4
  } csi_tx_state_t;
endpackage

// [csi_rec_if.sv]
// Carries the bus-off recovery handshake between the flag logic and its counter.
// Assumes both ends share one clock.
interface csi_rec_if;
  logic run;
  logic bus_free;
  logic done;
  modport ctl (output run, output bus_free, input done);
  modport cnt (input run, input bus_free, output done);
endinterface

// [csi_rec_cnt.sv]
// Counts bus-free pulses during bus-off recovery and flags completion.
// Assumes bus_free is a one-cycle pulse from logic on the same clock.
module csi_rec_cnt (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Recovery handshake
  csi_rec_if.cnt rec
);
  logic [csi_pkg::REC_CNT_W-1:0] cnt_ff;
  logic [csi_pkg::REC_CNT_W-1:0] nxt_cnt;
  logic done_ff;
  logic last_free;

  ////////////////////////////////////////////////////////////////////////////
  // Host re-entering init hold drops run and restarts the count from zero
  assign last_free = rec.run && rec.bus_free
                     && (cnt_ff == csi_pkg::BUS_FREE_COUNT - csi_pkg::REC_CNT_ONE);
  assign nxt_cnt = !rec.run ? csi_pkg::REC_CNT_ZERO :
                   last_free ? csi_pkg::REC_CNT_ZERO :
                   rec.bus_free ? cnt_ff + csi_pkg::REC_CNT_ONE : cnt_ff;
  assign rec.done = done_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= csi_pkg::REC_CNT_ZERO;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= last_free;
    end
  end
endmodule

// [csi_host_model.sv]
// Host model: drives the register port of the status and interrupt-flag block.
// Assumes one shared clock and read data in the single cycle after the strobe.
module csi_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [csi_pkg::ADDR_W-1:0] addr,
  output logic [csi_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [csi_pkg::DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so a stale value never passes for a hold
  task automatic wr_reg(input logic [csi_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [csi_pkg::ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    addr <= ~a;
    // Data are taken at the edge that closes their only valid cycle
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// [csi_status_irq_tb_top.sv]
// Self-checking bench for the status and interrupt-flag block.
// Assumes the host model above and a protocol engine played by this bench.
module csi_status_irq_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {logic w; logic [4:0] a; logic [7:0] d;} csi_row_t;
  localparam int ST = 0;
  localparam int DN = 1;
  localparam int AB = 2;
  localparam int OK = 3;
  localparam int BO = 4;
  localparam int BF = 5;
  logic clk, rst, rx_active, tx_active, warn_level, wr, rd;
  logic [5:0] ev;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, tx_buf_data, v;
  logic [3:0] tx_buf_idx;
  logic store_en, tx_request, err_cnt_clear, init_hold, sleep, tx_buf_we, irq_n;
  int num_errors = 0;
  int check_count = 0;
  int we_cnt = 0;
  int clr_cnt = 0;
  csi_row_t rows[9] = '{'{1'h1, 5'h00, 8'h1E}, '{1'h0, 5'h00, 8'h1E}, '{1'h0, 5'h01, 8'hFF},
    '{1'h0, 5'h02, 8'h0C}, '{1'h1, 5'h02, 8'hFF}, '{1'h0, 5'h02, 8'h0C},
    '{1'h1, 5'h03, 8'hFF}, '{1'h0, 5'h03, 8'h00}, '{1'h0, 5'h1F, 8'h00}};

  csi_status_irq i_csi_status_irq (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .msg_start(ev[ST]), .msg_done(ev[DN]),
    .msg_abort(ev[AB]), .rx_active(rx_active), .tx_active(tx_active), .tx_ok(ev[OK]),
    .warn_level(warn_level), .bus_off_evt(ev[BO]), .bus_free(ev[BF]),
    .store_en(store_en), .tx_request(tx_request), .err_cnt_clear(err_cnt_clear),
    .init_hold(init_hold), .sleep(sleep), .tx_buf_we(tx_buf_we), .tx_buf_idx(tx_buf_idx),
    .tx_buf_data(tx_buf_data), .irq_n(irq_n));
  csi_host_model i_csi_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tx_buf_we === 1'h1) we_cnt++;
    if (err_cnt_clear === 1'h1) clr_cnt++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'h1;
    @(posedge clk);
    ev[i] <= 1'h0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    i_csi_host_model.rd_reg(a, v);
    check(v & m, e);
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this margin is far beyond it
  initial begin
    #400000;
    num_errors++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    ev = 6'h00;
    rx_active = 1'h0;
    tx_active = 1'h0;
    warn_level = 1'h0;
    cyc(5);
    rst <= 1'h0;
    #1;
    check(init_hold, 1'h1);
    check(irq_n, 1'h1);
    foreach (rows[i]) begin
      if (rows[i].w) i_csi_host_model.wr_reg(rows[i].a, rows[i].d);
      else rd_chk(rows[i].a, 8'hFF, rows[i].d);
    end
    // Transmit buffer write while free is accepted
    i_csi_host_model.wr_reg(5'h0C, 8'h5A);
    cyc(2);
    check(8'(we_cnt), 8'h01);
    check({tx_buf_idx, 4'h0} ^ tx_buf_data, 8'h7A);
    // Receive path, overrun and drop
    pulse(ST);
    pulse(DN);
    rd_chk(5'h02, 8'hFF, 8'h0D);
    check(irq_n, 1'h0);
    rd_chk(5'h03, 8'hFF, 8'h01);
    check(irq_n, 1'h1);
    rd_chk(5'h03, 8'hFF, 8'h00);
    pulse(ST);
    pulse(DN);
    @(posedge clk);
    ev[ST] <= 1'h1;
    #1;
    check(store_en, 1'h0);
    @(posedge clk);
    ev[ST] <= 1'h0;
    pulse(DN);
    rd_chk(5'h02, 8'h02, 8'h02);
    rd_chk(5'h03, 8'h08, 8'h08);
    i_csi_host_model.wr_reg(5'h01, 8'h0C);
    rd_chk(5'h02, 8'hFF, 8'h0D);
    i_csi_host_model.wr_reg(5'h01, 8'h04);
    rd_chk(5'h02, 8'hFF, 8'h0C);
    pulse(ST);
    pulse(AB);
    rd_chk(5'h02, 8'h01, 8'h00);
    i_csi_host_model.rd_reg(5'h03, v);
    // Transmit, locked write, completion
    i_csi_host_model.wr_reg(5'h01, 8'h01);
    rd_chk(5'h02, 8'hFF, 8'h00);
    check(tx_request, 1'h1);
    i_csi_host_model.wr_reg(5'h0B, 8'h33);
    cyc(2);
    check(8'(we_cnt), 8'h01);
    tx_active <= 1'h1;
    rd_chk(5'h02, 8'hFF, 8'h20);
    pulse(OK);
    tx_active <= 1'h0;
    rd_chk(5'h02, 8'hFF, 8'h0C);
    rd_chk(5'h03, 8'hFF, 8'h02);
    // Cancel before sending
    i_csi_host_model.wr_reg(5'h01, 8'h01);
    i_csi_host_model.wr_reg(5'h01, 8'h02);
    rd_chk(5'h02, 8'hFF, 8'h04);
    rd_chk(5'h03, 8'h02, 8'h02);
    rx_active <= 1'h1;
    rd_chk(5'h02, 8'h30, 8'h10);
    rx_active <= 1'h0;
    // Error warning both ways
    warn_level <= 1'h1;
    rd_chk(5'h02, 8'h40, 8'h40);
    rd_chk(5'h03, 8'hFF, 8'h04);
    warn_level <= 1'h0;
    rd_chk(5'h02, 8'h40, 8'h00);
    rd_chk(5'h03, 8'hFF, 8'h04);
    // Bus-off and recovery after exactly 128 bus-free pulses
    pulse(BO);
    rd_chk(5'h02, 8'h80, 8'h80);
    rd_chk(5'h00, 8'h01, 8'h01);
    rd_chk(5'h03, 8'h04, 8'h04);
    i_csi_host_model.wr_reg(5'h00, 8'h1E);
    repeat (127) pulse(BF);
    cyc(3);
    check(8'(clr_cnt), 8'h00);
    rd_chk(5'h02, 8'h80, 8'h80);
    pulse(BF);
    cyc(4);
    check(8'(clr_cnt), 8'h01);
    rd_chk(5'h02, 8'hFF, 8'h0C);
    rd_chk(5'h03, 8'hFF, 8'h04);
    // Sleep and wake-up
    i_csi_host_model.wr_reg(5'h01, 8'h10);
    cyc(1);
    check(sleep, 1'h1);
    i_csi_host_model.wr_reg(5'h01, 8'h00);
    cyc(1);
    check(sleep, 1'h0);
    rd_chk(5'h03, 8'hFF, 8'h10);
    check(tx_request, 1'h0);
    end_of_test;
  end
endmodule
